// *** global_config_consts.svh ***
// Constants for the global configuration register bank
// Assumes inclusion by bare name from the design files
`ifndef GLOBAL_CONFIG_CONSTS_SVH
`define GLOBAL_CONFIG_CONSTS_SVH
`define ADDR_W 8
`define DATA_W 32
`define WRITE_FLAG 8'h80
`define REG_ADDR_MASK 8'h7f
`define GLOBAL_CONFIG_ADDR 8'h00
`define STATUS_ADDR 8'h01
`define EVENT_ADDR 8'h02
`define BIT_RECAL 0
`define BIT_FAST_STANDSTILL 1
`define BIT_PWM_EN 2
`define BIT_STEP_FILT 3
`define CFG_IMPL_MASK 32'h0000000f
`define CFG_RESET 32'h00000008
`define STANDSTILL_SHORT 32'h00040000
`define STANDSTILL_NORMAL 32'h00100000
`define ZERO32 32'h00000000
`endif

// *** global_config_host.sv ***
// Host model driving the register port
// Assumes one clock; changes follow the rising edge
`timescale 1ns/10ps
`default_nettype none
module global_config_host (
   input wire logic sys_clk,
   output logic [7:0] regAddr,
   output logic [31:0] regWdata,
   output logic regWr,
   output logic regRd
);
   logic [31:0] q[$];
   initial {regAddr, regWdata, regWr, regRd} = '0;
   // Reads note what they expect; one access per call keeps strobes apart
   task acc(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= w;
      regRd <= !w;
      if (!w)
      begin
         q.push_back(d);
      end
      @(posedge sys_clk);
      {regWr, regRd} <= 2'h0;
   endtask
endmodule
`default_nettype wire

// *** global_config_pkg.sv ***
// Types for the global configuration register bank
// Assumes the constants header is available
`default_nettype none
package global_config_pkg;
   typedef enum logic [0:0] {TIMER_IDLE = 1'b0, TIMER_RUN = 1'b1} timer_state_t;
   typedef struct packed {
      timer_state_t state;
      logic [31:0] count;
      logic standstill;
   } timer_regs_t;
   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] rdata;
      logic eventFlag;
   } bank_regs_t;
endpackage
`default_nettype wire

// *** global_config_register_bank.sv ***
// Global configuration register bank with standstill detection
// Assumes a plain register port synchronous to sys_clk
// Contract
// RULE1 - After reset every register is zero except fields documented otherwise.
// RULE2 - A write carries the register address plus 0x80 and a read uses the plain address.
// RULE3 - Each register keeps its access class, and a clear-on-read register clears when read.
// RULE4 - With bit 0 set, zero crossing recalibrates while the driver is disabled by pin or off time.
// RULE5 - Standstill is flagged 2^18 clocks after the last step with bit 1 set, else 2^20 clocks.
// RULE6 - Bit 2 enables the voltage-mode chopper, still subject to velocity thresholds.
// RULE7 - The host sets bit 2 only at standstill with hold current equal to run current.
// RULE8 - Bit 3 enables step input filtering and resets to one.
// RULE9 - Unimplemented configuration bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "global_config_consts.svh"
module global_config_register_bank #(
   parameter logic [31:0] SHORT_CLKS = `STANDSTILL_SHORT,
   parameter logic [31:0] NORMAL_CLKS = `STANDSTILL_NORMAL
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic stepIn,
   input wire logic driver_enable_n,
   input wire logic chopperOff,
   input wire logic pwmThresholdOk,
   output logic recalActive,
   output logic pwmChopperOn,
   output logic stepFilterEn,
   output logic standstill
);
   standstill_if link ();
   global_config_pkg::bank_regs_t state_r;
   global_config_pkg::bank_regs_t state_nxt;
   logic isWrite;
   logic [7:0] plainAddr;
   logic recalNxt;
   logic pwmNxt;
   logic standPrev_r;

   standstill_timer #(
      .SHORT_CLKS(SHORT_CLKS),
      .NORMAL_CLKS(NORMAL_CLKS)
   ) timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .link(link)
   );

   assign link.fastMode = state_r.cfg[`BIT_FAST_STANDSTILL]; // RULE5
   assign link.stepPulse = stepIn;

   always_comb
   begin
      isWrite = (regAddr & `WRITE_FLAG) != 8'h00; // RULE2
      plainAddr = regAddr & `REG_ADDR_MASK; // RULE2
      state_nxt = state_r;
      state_nxt.rdata = `ZERO32;
      // Standstill entry is the event; set wins over a clearing read
      if (regRd && !isWrite)
      begin
         unique case (plainAddr)
            `GLOBAL_CONFIG_ADDR: state_nxt.rdata = state_r.cfg & `CFG_IMPL_MASK; // RULE9
            `STATUS_ADDR: state_nxt.rdata = {31'h00000000, link.standstill};
            `EVENT_ADDR:
            begin
               state_nxt.rdata = {31'h00000000, state_r.eventFlag};
               state_nxt.eventFlag = 1'b0; // RULE3
            end
            default: state_nxt.rdata = `ZERO32;
         endcase
      end
      if (regWr && isWrite && plainAddr == `GLOBAL_CONFIG_ADDR)
      begin
         state_nxt.cfg = regWdata & `CFG_IMPL_MASK; // RULE9
      end
      if (link.standstill && !standPrev_r)
      begin
         state_nxt.eventFlag = 1'b1; // RULE3
      end
      recalNxt = state_nxt.cfg[`BIT_RECAL] && (driver_enable_n || chopperOff); // RULE4
      pwmNxt = state_nxt.cfg[`BIT_PWM_EN] && pwmThresholdOk; // RULE6
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= '{`CFG_RESET, `ZERO32, 1'b0}; // RULE1 RULE8
         standPrev_r <= 1'b1;
         recalActive <= 1'b0;
         pwmChopperOn <= 1'b0;
         stepFilterEn <= 1'b1; // RULE8
         standstill <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         standPrev_r <= link.standstill;
         recalActive <= recalNxt;
         pwmChopperOn <= pwmNxt;
         stepFilterEn <= state_nxt.cfg[`BIT_STEP_FILT]; // RULE8
         standstill <= link.standstill;
      end
   end

   assign regRdata = state_r.rdata;
endmodule
`default_nettype wire

// *** global_config_register_bank_asserts.sv ***
// Checker for the register bank ports
// Assumes config written only at its write address
`timescale 1ns/10ps
`default_nettype none
module global_config_register_bank_asserts (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire logic stepIn,
   input wire logic driver_enable_n,
   input wire logic chopperOff,
   input wire logic pwmThresholdOk,
   input wire logic recalActive,
   input wire logic pwmChopperOn,
   input wire logic stepFilterEn,
   input wire logic standstill
);
   logic [3:0] cfg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n) cfg <= 4'h8;
      else if (regWr && regAddr == 8'h80) cfg <= regWdata[3:0];
   a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0) else $error("rdata not idle");
   a_cfg_high_zero: assert property ($past(regRd) && $past(regAddr) == 8'h00 |-> regRdata[31:4] == 28'h0)
      else $error("cfg high bits");
   a_cfg_read: assert property ($past(regRd) && $past(regAddr) == 8'h00 |-> regRdata[3:0] == $past(cfg))
      else $error("cfg read");
   a_filter_copy: assert property (stepFilterEn == cfg[3]) else $error("filter enable");
   a_recal_gate: assert property (recalActive == (cfg[0] && ($past(driver_enable_n) || $past(chopperOff))))
      else $error("recal");
   a_pwm_gate: assert property (pwmChopperOn == (cfg[2] && $past(pwmThresholdOk))) else $error("pwm");
   a_plain_write: assert property (regWr && regAddr == 8'h00 |=> $stable(stepFilterEn))
      else $error("plain write");
   a_step_clears: assert property (stepIn |-> ##2 !standstill) else $error("standstill after step");
   // Pin drops two edges after a step, never on its own
   a_standstill_hold: assert property ($past(standstill) && !$past(stepIn, 2) |-> standstill)
      else $error("standstill dropped without step");
   c_step: cover property (stepIn);
   c_recal: cover property (recalActive);
   c_pwm: cover property (pwmChopperOn);
   c_standstill: cover property ($rose(standstill));
endmodule
bind global_config_register_bank global_config_register_bank_asserts chk (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .regAddr(regAddr),
   .regWdata(regWdata),
   .regWr(regWr),
   .regRd(regRd),
   .regRdata(regRdata),
   .stepIn(stepIn),
   .driver_enable_n(driver_enable_n),
   .chopperOff(chopperOff),
   .pwmThresholdOk(pwmThresholdOk),
   .recalActive(recalActive),
   .pwmChopperOn(pwmChopperOn),
   .stepFilterEn(stepFilterEn),
   .standstill(standstill)
);
`default_nettype wire

// *** global_config_register_bank_test.sv ***
// Self-checking bench for the register bank
// Assumes short standstill counts of 16 and 64
`timescale 1ns/10ps
`default_nettype none
module global_config_register_bank_test;
   logic sys_clk = 0, rst_n = 0, stepIn = 0, den = 0, coff = 0, thr = 0, rdPend = 0;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, d;
   logic regWr, regRd;
   int err_count = 0, n_checks = 0, cyc = 0, seed = 93442;
   global_config_host h (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd));
   global_config_register_bank #(.SHORT_CLKS(32'h10), .NORMAL_CLKS(32'h40)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .stepIn(stepIn),
      .driver_enable_n(den), .chopperOff(coff), .pwmThresholdOk(thr), .recalActive(), .pwmChopperOn(),
      .stepFilterEn(), .standstill());
   initial forever #12.5 sys_clk = ~sys_clk;
   task test_done;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] regRdata expected %h seen %h", e, g);
      end
   endtask
   task step;
      @(posedge sys_clk) stepIn <= 1;
      @(posedge sys_clk) stepIn <= 0;
   endtask
   // Random pin levels keep the gating outputs busy
   always @(posedge sys_clk)
   begin
      {den, coff, thr} <= 3'($random(seed));
      rdPend <= regRd;
      if (++cyc > 2000)
      begin
         err_count++;
         test_done;
      end
   end
   always @(negedge sys_clk) if (rdPend) chk(h.q.pop_front(), regRdata);
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1;
      h.acc(8'h00, 32'h8, 0);
      h.acc(8'h05, 32'h0, 0);
      h.acc(8'h02, 32'h0, 0);
      h.acc(8'h80, 32'h0, 0);
      d = $random(seed);
      h.acc(8'h80, d, 1);
      h.acc(8'h00, d & 32'hf, 0);
      h.acc(8'h00, 32'h3, 1);
      h.acc(8'h00, d & 32'hf, 0);
      h.acc(8'h80, 32'h2, 1);
      step();
      repeat (20) @(posedge sys_clk);
      h.acc(8'h01, 32'h1, 0);
      h.acc(8'h02, 32'h1, 0);
      h.acc(8'h02, 32'h0, 0);
      h.acc(8'h80, 32'h0, 1);
      step();
      repeat (20) @(posedge sys_clk);
      h.acc(8'h01, 32'h0, 0);
      repeat (50) @(posedge sys_clk);
      h.acc(8'h01, 32'h1, 0);
      h.acc(8'h80, 32'h5, 1);
      repeat (20) @(posedge sys_clk);
      test_done;
   end
endmodule
`default_nettype wire

// *** standstill_if.sv ***
// Interface between the register bank and the standstill timer
// Assumes a single clock domain
`timescale 1ns/10ps
`default_nettype none
interface standstill_if;
   logic fastMode;
   logic stepPulse;
   logic standstill;
   modport bank (output fastMode, output stepPulse, input standstill);
   modport timer (input fastMode, input stepPulse, output standstill);
endinterface
`default_nettype wire

// *** standstill_timer.sv ***
// Standstill detection timer restarted by each step
// Assumes steps arrive synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
`include "global_config_consts.svh"
module standstill_timer #(
   parameter logic [31:0] SHORT_CLKS = `STANDSTILL_SHORT,
   parameter logic [31:0] NORMAL_CLKS = `STANDSTILL_NORMAL
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   standstill_if.timer link
);
   global_config_pkg::timer_regs_t state_r;
   global_config_pkg::timer_regs_t state_nxt;
   logic [31:0] limit;

   always_comb
   begin
      limit = link.fastMode ? SHORT_CLKS : NORMAL_CLKS; // RULE5
      state_nxt = state_r;
      unique case (state_r.state)
         global_config_pkg::TIMER_IDLE:
         begin
            if (link.stepPulse)
            begin
               state_nxt.state = global_config_pkg::TIMER_RUN;
               state_nxt.count = `ZERO32;
               state_nxt.standstill = 1'b0;
            end
         end
         global_config_pkg::TIMER_RUN:
         begin
            if (link.stepPulse)
            begin
               state_nxt.count = `ZERO32;
            end
            // Mode change mid-count applies to the current wait
            else if (state_r.count + 32'h00000001 >= limit) // RULE5
            begin
               state_nxt.state = global_config_pkg::TIMER_IDLE;
               state_nxt.standstill = 1'b1;
            end
            else
            begin
               state_nxt.count = state_r.count + 32'h00000001;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= '{global_config_pkg::TIMER_IDLE, `ZERO32, 1'b1};
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign link.standstill = state_r.standstill;
endmodule
`default_nettype wire
